/* File: src/tos_top.sv */
// test observe and self-test logic: self test, test bus, aux selectors, prbs
// assumes synchronous probe inputs and that software keeps its own sequence
`timescale 1ns/100ps
module tos_top
   import tos_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [7:0] self_test_control_reg,
   input wire logic crc_calc_command,
   input wire logic transmit_command,
   input wire logic [4:0] test_bus_group_select,
   input wire logic [2:0] test_bus_line_select,
   input wire logic [1:0] prbs_select,
   input wire logic [3:0] aux_a_source_select,
   input wire logic [3:0] aux_b_source_select,
   input wire logic [5:0] test_dac_a_reg,
   input wire logic [5:0] test_dac_b_reg,
   input wire tos_rx_probe_t rx_probe,
   input wire tos_analog_t analog_probe,
   input wire tos_frame_t frame,
   input wire logic osc_stable,
   input wire logic subcarrier_detected,
   output logic [6:1] data_pin_out,
   output logic [6:1] data_pin_oe,
   output logic [5:0] aux_pin_a,
   output logic aux_pin_a_oe,
   output logic [5:0] aux_pin_b,
   output logic aux_pin_b_oe,
   output logic crc_start,
   output logic fifo_wr,
   output logic [7:0] fifo_wdata,
   output logic self_test_busy,
   output logic self_test_done,
   output logic prbs_bit,
   output logic prbs_active
);
   tos_state_t st_q, st_d;
   logic [6:0] cnt_q, cnt_d;
   logic wr_pend_q, wr_pend_d;
   logic crc_start_d, fifo_wr_d;
   logic [7:0] fifo_wdata_d;
   logic [5:0] rom_addr;
   logic [7:0] rom_data;

   assign rom_addr = cnt_d[5:0];

   tos_sig_rom u_rom (
      .ref_clk(ref_clk),
      .rst(rst),
      .ce(ce),
      .addr(rom_addr),
      .rdata(rom_data)
   );

   // self-test sequencer
   always_comb
   begin
      st_d = st_q;
      cnt_d = cnt_q;
      wr_pend_d = 1'b0;
      fifo_wr_d = 1'b0;
      fifo_wdata_d = fifo_wdata;
      crc_start_d = 1'b0;
      case (st_q)
         TOS_ST_IDLE:
         begin
            if (crc_calc_command && self_test_control_reg == TOS_ARM_CODE)
            begin
               st_d = TOS_ST_RUN;
               cnt_d = 7'h00;
               wr_pend_d = 1'b1;
            end
            else if (crc_calc_command)
               crc_start_d = 1'b1;
         end
         TOS_ST_RUN:
         begin
            if (wr_pend_q)
            begin
               fifo_wr_d = 1'b1;
               fifo_wdata_d = rom_data;
               if (cnt_q == TOS_SIG_LAST)
                  st_d = TOS_ST_DONE;
               else
                  cnt_d = cnt_q + 7'h01;
            end
            else
               wr_pend_d = 1'b1;
         end
         TOS_ST_DONE:
         begin
            if (self_test_control_reg != TOS_ARM_CODE)
               st_d = TOS_ST_IDLE;
            else if (crc_calc_command)
            begin
               st_d = TOS_ST_RUN;
               cnt_d = 7'h00;
               wr_pend_d = 1'b1;
            end
         end
         default:
            st_d = TOS_ST_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         st_q <= TOS_ST_IDLE;
         cnt_q <= 7'h00;
         wr_pend_q <= 1'b0;
         fifo_wr <= 1'b0;
         fifo_wdata <= 8'h00;
         crc_start <= 1'b0;
         self_test_busy <= 1'b0;
         self_test_done <= 1'b0;
      end
      else if (ce)
      begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         wr_pend_q <= wr_pend_d;
         fifo_wr <= fifo_wr_d;
         fifo_wdata <= fifo_wdata_d;
         crc_start <= crc_start_d;
         self_test_busy <= (st_d == TOS_ST_RUN);
         self_test_done <= (st_d == TOS_ST_DONE);
      end
   end

   // oscillator divide by 8 and prbs generator
   logic [1:0] div_q, div_d;
   logic div8_q, div8_d;
   logic [14:0] lfsr_q, lfsr_d;
   logic prbs_on_q, prbs_on_d;
   logic prbs_bit_d;

   always_comb
   begin
      div_d = div_q + 2'h1;
      div8_d = div8_q;
      if (div_q == TOS_DIV_LAST)
         div8_d = ~div8_q;
      prbs_on_d = prbs_on_q;
      lfsr_d = lfsr_q;
      prbs_bit_d = prbs_bit;
      if (prbs_select == TOS_PRBS_OFF)
         prbs_on_d = 1'b0;
      else if (transmit_command)
      begin
         prbs_on_d = 1'b1;
         lfsr_d = TOS_LFSR_SEED;
      end
      // framing bits are inserted by the transmitter, lfsr holds meanwhile
      else if (prbs_on_q && frame.tx_on && !frame.tx_start_bit && !frame.tx_parity_bit)
      begin
         if (prbs_select == TOS_PRBS_9)
         begin
            prbs_bit_d = lfsr_q[8];
            lfsr_d = {6'h00, lfsr_q[7:0], lfsr_q[8] ^ lfsr_q[4]};
         end
         else
         begin
            prbs_bit_d = lfsr_q[14];
            lfsr_d = {lfsr_q[13:0], lfsr_q[14] ^ lfsr_q[13]};
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         div_q <= 2'h0;
         div8_q <= 1'b0;
         lfsr_q <= TOS_LFSR_SEED;
         prbs_on_q <= 1'b0;
         prbs_bit <= 1'b0;
         prbs_active <= 1'b0;
      end
      else if (ce)
      begin
         div_q <= div_d;
         div8_q <= div8_d;
         lfsr_q <= lfsr_d;
         prbs_on_q <= prbs_on_d;
         prbs_bit <= prbs_bit_d;
         prbs_active <= prbs_on_d;
      end
   end

   // test bus routing and activity flags
   logic [6:1] tbus;
   logic [6:1] tbus_oe;
   logic tx_act, rx_act, line_bit;
   logic [7:0] tbus_ext;

   always_comb
   begin
      tbus = 6'h00;
      tbus_oe = 6'h00;
      case (test_bus_group_select)
         TOS_GRP_RX:
         begin
            tbus = {rx_probe.rx_data, rx_probe.rx_coll & frame.rate_106, rx_probe.rx_valid,
                    rx_probe.rx_stop, rx_probe.receiver_reset, 1'b0};
            tbus_oe = 6'b111110;
         end
         TOS_GRP_OSC:
         begin
            tbus = {osc_stable, div8_q, 2'b00, div_q[0], 1'b0}; // clock divided by 2, toggling at flop rate
            tbus_oe = 6'b110010;
         end
         default:
         begin
            tbus = 6'h00;
            tbus_oe = 6'h00;
         end
      endcase
      // rx excludes start bits always; parity only counts at 106 kBd
      rx_act = frame.rx_on && !frame.rx_start_bit
               && (frame.rate_106 || !frame.rx_parity_bit);
      tx_act = frame.tx_on && (frame.rate_106
               || (!frame.tx_start_bit && !frame.tx_parity_bit));
      tbus_ext = {1'b0, tbus, 1'b0}; // lines 0 and 7 read as zero
      line_bit = tbus_ext[test_bus_line_select];
   end

   function automatic logic [6:0] tos_aux_mux(input logic [3:0] sel, input logic [5:0] dac,
                                              input tos_analog_t an, input logic tx,
                                              input logic rx, input logic subc,
                                              input logic lb);
      logic [6:0] r;
      r = 7'h00;
      case (sel)
         TOS_SRC_DAC: r = {1'b1, dac};
         TOS_SRC_CORR: r = {1'b1, an.correlation_probe};
         TOS_SRC_MIN: r = {1'b1, an.min_level_probe};
         TOS_SRC_ADCI: r = {1'b1, an.adc_i};
         TOS_SRC_ADCQ: r = {1'b1, an.adc_q};
         TOS_SRC_HIGH: r = {1'b1, TOS_DAC_MAX};
         TOS_SRC_LOW: r = 7'h40;
         TOS_SRC_TX: r = {1'b1, {6{tx}}};
         TOS_SRC_RX: r = {1'b1, {6{rx}}};
         TOS_SRC_SUBC: r = {1'b1, {6{subc}}};
         TOS_SRC_LINE: r = {1'b1, {6{lb}}};
         default: r = 7'h00;
      endcase
      return r;
   endfunction

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         data_pin_out <= 6'h00;
         data_pin_oe <= 6'h00;
         {aux_pin_a_oe, aux_pin_a} <= 7'h00;
         {aux_pin_b_oe, aux_pin_b} <= 7'h00;
      end
      else if (ce)
      begin
         data_pin_out <= tbus;
         data_pin_oe <= tbus_oe;
         {aux_pin_a_oe, aux_pin_a} <= tos_aux_mux(aux_a_source_select, test_dac_a_reg,
            analog_probe, tx_act, rx_act, subcarrier_detected, line_bit);
         {aux_pin_b_oe, aux_pin_b} <= tos_aux_mux(aux_b_source_select, test_dac_b_reg,
            analog_probe, tx_act, rx_act, subcarrier_detected, line_bit);
      end
   end

   // self test must write exactly 64 bytes, one per two cycles
   sequence tos_arm_seq;
      (st_q == TOS_ST_IDLE) && crc_calc_command && self_test_control_reg == TOS_ARM_CODE && ce;
   endsequence

   AST_ARM_STARTS: assert property (@(posedge ref_clk) disable iff (rst)
      tos_arm_seq |=> (st_q == TOS_ST_RUN) && !crc_start)
      else $error("armed crc command did not start self test");

   AST_NO_ARM_CRC: assert property (@(posedge ref_clk) disable iff (rst)
      (st_q == TOS_ST_IDLE) && crc_calc_command && ce
      && self_test_control_reg != TOS_ARM_CODE |=> crc_start)
      else $error("unarmed crc command lost");

   AST_SIG_END: assert property (@(posedge ref_clk) disable iff (rst || !ce)
      tos_arm_seq |-> ##129 self_test_done)
      else $error("signature not done in 129 cycles");

   AST_SIG_LAST: assert property (@(posedge ref_clk) disable iff (rst)
      fifo_wr && self_test_done |-> $past(cnt_q) == TOS_SIG_LAST)
      else $error("signature length wrong");

   AST_GRP_OSC: assert property (@(posedge ref_clk) disable iff (rst)
      ce && test_bus_group_select == TOS_GRP_OSC |=> data_pin_oe == 6'b110010)
      else $error("osc group enables wrong");

   AST_GRP_RX: assert property (@(posedge ref_clk) disable iff (rst)
      ce && test_bus_group_select == TOS_GRP_RX |=> data_pin_out[6] == $past(rx_probe.rx_data))
      else $error("rx stream not on d6");

   AST_GRP_OFF: assert property (@(posedge ref_clk) disable iff (rst)
      ce && test_bus_group_select != TOS_GRP_RX && test_bus_group_select != TOS_GRP_OSC
      |=> data_pin_oe == 6'h00)
      else $error("test bus driven for unused group");

   AST_AUX_DAC: assert property (@(posedge ref_clk) disable iff (rst)
      ce && aux_a_source_select == TOS_SRC_DAC |=> aux_pin_a_oe && aux_pin_a == $past(test_dac_a_reg))
      else $error("aux a dac level wrong");

   AST_AUX_OFF: assert property (@(posedge ref_clk) disable iff (rst)
      ce && aux_b_source_select == TOS_SRC_OFF |=> !aux_pin_b_oe)
      else $error("aux b not three-state");

   AST_AUX_HIGH: assert property (@(posedge ref_clk) disable iff (rst)
      ce && aux_a_source_select == TOS_SRC_HIGH |=> aux_pin_a == TOS_DAC_MAX)
      else $error("aux a not high");

   AST_RX_START: assert property (@(posedge ref_clk) disable iff (rst)
      ce && aux_b_source_select == TOS_SRC_RX && frame.rx_start_bit |=> aux_pin_b == 6'h00)
      else $error("rx active over start bit");

   AST_TX_HI_RATE: assert property (@(posedge ref_clk) disable iff (rst)
      ce && aux_a_source_select == TOS_SRC_TX && !frame.rate_106 && frame.tx_start_bit
      |=> aux_pin_a == 6'h00)
      else $error("tx active over start bit at high rate");

   AST_LINE_D6: assert property (@(posedge ref_clk) disable iff (rst)
      ce && aux_a_source_select == TOS_SRC_LINE && test_bus_line_select == 3'h6
      && test_bus_group_select == TOS_GRP_RX |=> aux_pin_a[0] == $past(rx_probe.rx_data))
      else $error("line select 6 not d6");

   AST_PRBS_ON: assert property (@(posedge ref_clk) disable iff (rst)
      ce && transmit_command && prbs_select != TOS_PRBS_OFF |=> prbs_active)
      else $error("prbs did not start");
endmodule

/* File: src/tos_pkg.sv */
// package for the test observe and self-test block
// assumes one 10 MHz clock, async active-high reset, no register bus
// Operation
// - when armed, crc calc command starts self test instead of crc
// - self test leaves exactly 64 signature bytes in the fifo
// - 5-bit group select routes one of two signal sets onto data pins
// - group 07h: rx stream, collision, valid, stop, receiver reset; d1 reserved; collision is shown at 106 kBd only, else zero
// - group 0dh: stable osc, osc divided by 8, raw osc; rest reserved; d2 carries osc divided by 2 in place of raw osc
// - 4-bit aux source codes: off, own dac, correlation, min level, adc i, adc q
// - codes 1010 high, 1011 low, tx, rx, subcarrier, test bus line; others reserved
// - 106 kBd: rx active excludes start bits, tx active includes them
// - higher rates: both flags only over data and crc bits
// - 3-bit line select feeds aux test bus source; 06h picks d6
// - test dac registers set aux dac levels, codes up to 3fh
// - prbs9 or prbs15 selected: transmit command sends it with framing added
package tos_pkg;
   localparam logic [7:0] TOS_ARM_CODE = 8'h09;
   localparam logic [4:0] TOS_GRP_RX = 5'h07;
   localparam logic [4:0] TOS_GRP_OSC = 5'h0d;
   localparam logic [3:0] TOS_SRC_OFF = 4'h0;
   localparam logic [3:0] TOS_SRC_DAC = 4'h1;
   localparam logic [3:0] TOS_SRC_CORR = 4'h2;
   localparam logic [3:0] TOS_SRC_MIN = 4'h4;
   localparam logic [3:0] TOS_SRC_ADCI = 4'h5;
   localparam logic [3:0] TOS_SRC_ADCQ = 4'h6;
   localparam logic [3:0] TOS_SRC_HIGH = 4'ha;
   localparam logic [3:0] TOS_SRC_LOW = 4'hb;
   localparam logic [3:0] TOS_SRC_TX = 4'hc;
   localparam logic [3:0] TOS_SRC_RX = 4'hd;
   localparam logic [3:0] TOS_SRC_SUBC = 4'he;
   localparam logic [3:0] TOS_SRC_LINE = 4'hf;
   localparam logic [5:0] TOS_DAC_MAX = 6'h3f;
   localparam int TOS_SIG_LEN = 64;
   localparam logic [6:0] TOS_SIG_LAST = 7'h3f;
   localparam logic [1:0] TOS_DIV_LAST = 2'h3;
   localparam logic [1:0] TOS_PRBS_OFF = 2'h0;
   localparam logic [1:0] TOS_PRBS_9 = 2'h1;
   localparam logic [1:0] TOS_PRBS_15 = 2'h2;
   localparam logic [14:0] TOS_LFSR_SEED = 15'h7fff;
   // arbitrary neutral silicon version
   localparam logic [7:0] TOS_VERSION = 8'h5a;

   typedef enum logic [2:0] {
      TOS_ST_IDLE = 3'b001,
      TOS_ST_RUN = 3'b010,
      TOS_ST_DONE = 3'b100
   } tos_state_t;

   typedef struct packed {
      logic rx_data;
      logic rx_coll;
      logic rx_valid;
      logic rx_stop;
      logic receiver_reset;
   } tos_rx_probe_t;

   typedef struct packed {
      logic [5:0] correlation_probe;
      logic [5:0] min_level_probe;
      logic [5:0] adc_i;
      logic [5:0] adc_q;
   } tos_analog_t;

   typedef struct packed {
      logic tx_on;
      logic tx_start_bit;
      logic tx_parity_bit;
      logic rx_on;
      logic rx_start_bit;
      logic rx_parity_bit;
      logic rate_106;
   } tos_frame_t;
endpackage

/* File: src/tos_sig_rom.sv */
// signature memory of the self test, 64 bytes, registered read data
// assumes a constant table, address held stable by the caller
`timescale 1ns/100ps
module tos_sig_rom
   import tos_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [5:0] addr,
   output logic [7:0] rdata
);
   logic [7:0] rdata_d;

   // signature: table stepped by an lfsr, seeded by the silicon version
   always_comb
   begin
      logic [7:0] v;
      v = TOS_VERSION ^ {2'h0, addr};
      for (int i = 0; i < 4; i++)
      begin
         v = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
      end
      rdata_d = v;
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         rdata <= 8'h00;
      else if (ce)
         rdata <= rdata_d;
   end
endmodule

/* File: dv/tos_probe_model.sv */
// probe model: resolves the levels seen by test equipment on aux and data pins
// assumes 1 kohm pull-down on each aux pin; data pins float when not driven
`timescale 1ns/100ps
module tos_probe_model
   import tos_pkg::*;
(
   input wire logic ref_clk,
   input wire logic [6:1] data_pin_out,
   input wire logic [6:1] data_pin_oe,
   input wire logic [5:0] aux_pin_a,
   input wire logic aux_pin_a_oe,
   input wire logic [5:0] aux_pin_b,
   input wire logic aux_pin_b_oe,
   output logic [6:1] data_level,
   output logic [5:0] aux_a_level,
   output logic [5:0] aux_b_level
);
   logic [6:1] last_q = 6'h00;
   // released aux pin is pulled to ground
   assign aux_a_level = aux_pin_a_oe ? aux_pin_a : 6'h00;
   assign aux_b_level = aux_pin_b_oe ? aux_pin_b : 6'h00;
   // floating data pin shows the inverse of its last driven value
   always @(posedge ref_clk)
   begin
      for (int i = 1; i <= 6; i++)
      begin
         if (data_pin_oe[i])
            last_q[i] <= data_pin_out[i];
      end
   end
   always_comb
   begin
      for (int i = 1; i <= 6; i++)
      begin
         data_level[i] = data_pin_oe[i] ? data_pin_out[i] : ~last_q[i];
      end
   end
endmodule

/* File: dv/tb_top.sv */
// self-checking bench of the test observe and self-test block
// assumes inputs change 10 ns after the rising edge and outputs are one cycle late
`timescale 1ns/100ps
module tb_top;
   import tos_pkg::*;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic [7:0] ctrl = 8'h00;
   logic crc_cmd = 1'b0, tx_cmd = 1'b0;
   logic [4:0] grp = 5'h00;
   logic [2:0] line = 3'h0;
   logic [1:0] prbs = 2'h0;
   logic [3:0] sel_a = 4'h0, sel_b = 4'h0;
   logic [5:0] dac_a = 6'h00, dac_b = 6'h00;
   tos_rx_probe_t rxp = '0;
   tos_analog_t anp = '0;
   tos_frame_t frm = '0;
   logic osc_ok = 1'b0, subc = 1'b0;
   logic [6:1] d_out, d_oe, d_lvl;
   logic [5:0] aux_a, aux_b, lvl_a, lvl_b;
   logic aux_a_oe, aux_b_oe, crc_start, fifo_wr, busy, done, prbs_bit, prbs_active;
   logic [7:0] fifo_wdata;
   int num_errors = 0;
   int num_checks = 0;

   always #50 ref_clk = ~ref_clk;

   tos_top i_dut (.ref_clk(ref_clk), .rst(rst), .ce(ce), .self_test_control_reg(ctrl),
      .crc_calc_command(crc_cmd), .transmit_command(tx_cmd), .test_bus_group_select(grp),
      .test_bus_line_select(line), .prbs_select(prbs), .aux_a_source_select(sel_a),
      .aux_b_source_select(sel_b), .test_dac_a_reg(dac_a), .test_dac_b_reg(dac_b),
      .rx_probe(rxp), .analog_probe(anp), .frame(frm), .osc_stable(osc_ok),
      .subcarrier_detected(subc), .data_pin_out(d_out), .data_pin_oe(d_oe),
      .aux_pin_a(aux_a), .aux_pin_a_oe(aux_a_oe), .aux_pin_b(aux_b),
      .aux_pin_b_oe(aux_b_oe), .crc_start(crc_start), .fifo_wr(fifo_wr),
      .fifo_wdata(fifo_wdata), .self_test_busy(busy), .self_test_done(done),
      .prbs_bit(prbs_bit), .prbs_active(prbs_active));

   tos_probe_model i_probe (.ref_clk(ref_clk), .data_pin_out(d_out), .data_pin_oe(d_oe),
      .aux_pin_a(aux_a), .aux_pin_a_oe(aux_a_oe), .aux_pin_b(aux_b),
      .aux_pin_b_oe(aux_b_oe), .data_level(d_lvl), .aux_a_level(lvl_a),
      .aux_b_level(lvl_b));

   task automatic step();
      @(posedge ref_clk);
      #10;
   endtask

   task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
      num_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic end_sim();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic t_self_test();
      logic [7:0] sig [64];
      int n;
      rst = 1'b1;
      step();
      rst = 1'b0;
      crc_cmd = 1'b1;
      step();
      chk("crc_start", 8'h01, {7'h00, crc_start});
      crc_cmd = 1'b0;
      ctrl = TOS_ARM_CODE;
      step();
      // second run restarts from done and must repeat the same signature
      for (int r = 0; r < 2; r++)
      begin
         crc_cmd = 1'b1;
         step();
         chk("self_test_busy", 8'h01, {7'h00, busy});
         n = 0;
         for (int i = 0; i < 140; i++)
         begin
            crc_cmd = (r == 1 && i == 20);
            step();
            if (fifo_wr === 1'b1)
            begin
               if (r == 1 && n < 64)
                  chk("signature byte", sig[n], fifo_wdata);
               else if (n < 64)
                  sig[n] = fifo_wdata;
               n++;
            end
         end
         chk("fifo byte count", 8'(TOS_SIG_LEN), 8'(n));
         chk("self_test_done", 8'h01, {7'h00, done});
         chk("self_test_busy", 8'h00, {7'h00, busy});
      end
      ctrl = 8'h00;
      step();
      step();
      chk("done cleared", 8'h00, {7'h00, done});
   endtask

   task automatic t_test_bus();
      int n5, n2;
      logic l5, l2;
      rxp = 5'b11010;
      frm.rate_106 = 1'b1;
      osc_ok = 1'b1;
      grp = TOS_GRP_RX;
      step();
      step();
      chk("rx group pins", {3'h0, rxp}, {3'h0, d_lvl[6:2]});
      chk("rx group enables", 8'h3e, {2'h0, d_oe});
      rxp = 5'b01000;
      frm.rate_106 = 1'b0;
      step();
      step();
      chk("collision above 106", 8'h00, {7'h00, d_lvl[5]});
      grp = TOS_GRP_OSC;
      step();
      step();
      chk("osc stable pin", 8'h01, {7'h00, d_lvl[6]});
      chk("osc group enables", 8'h32, {2'h0, d_oe});
      n5 = 0;
      n2 = 0;
      l5 = d_lvl[5];
      l2 = d_lvl[2];
      for (int i = 0; i < 16; i++)
      begin
         step();
         n5 += (d_lvl[5] !== l5);
         n2 += (d_lvl[2] !== l2);
         l5 = d_lvl[5];
         l2 = d_lvl[2];
      end
      chk("osc div8 changes", 8'h04, 8'(n5));
      chk("osc raw changes", 8'h10, 8'(n2));
      ce = 1'b0;
      n2 = 0;
      for (int i = 0; i < 8; i++)
      begin
         step();
         n2 += (d_lvl[2] !== l2);
      end
      ce = 1'b1;
      chk("clock enable freeze", 8'h00, 8'(n2));
   endtask

   task automatic t_aux();
      logic [3:0] codes [13] = '{TOS_SRC_OFF, TOS_SRC_DAC, TOS_SRC_CORR, TOS_SRC_MIN,
         TOS_SRC_ADCI, TOS_SRC_ADCQ, TOS_SRC_HIGH, TOS_SRC_LOW, TOS_SRC_TX, TOS_SRC_RX,
         TOS_SRC_SUBC, 4'h3, 4'h8};
      // oe bit above the six level bits
      logic [6:0] exps [13] = '{7'h00, 7'h7f, 7'h55, 7'h6a, 7'h4c, 7'h73, 7'h7f, 7'h40,
         7'h7f, 7'h40, 7'h7f, 7'h00, 7'h00};
      string nm;
      anp = {6'h15, 6'h2a, 6'h0c, 6'h33};
      dac_a = TOS_DAC_MAX;
      dac_b = 6'h2a;
      subc = 1'b1;
      frm = '{tx_on: 1'b1, tx_start_bit: 1'b1, tx_parity_bit: 1'b0, rx_on: 1'b1,
         rx_start_bit: 1'b1, rx_parity_bit: 1'b0, rate_106: 1'b1};
      for (int i = 0; i < 13; i++)
      begin
         sel_a = codes[i];
         step();
         step();
         nm = $sformatf("aux a code %h", codes[i]);
         chk(nm, {1'h0, exps[i]}, {1'h0, aux_a_oe, lvl_a});
      end
      sel_b = TOS_SRC_DAC;
      step();
      step();
      chk("aux b dac", 8'h2a, {2'h0, lvl_b});
      frm.rate_106 = 1'b0;
      sel_a = TOS_SRC_TX;
      sel_b = TOS_SRC_RX;
      step();
      step();
      chk("tx active start bit", 8'h00, {2'h0, lvl_a});
      chk("rx active start bit", 8'h00, {2'h0, lvl_b});
      frm = '{tx_on: 1'b1, rx_on: 1'b1, default: 1'b0};
      step();
      step();
      chk("tx active data bit", 8'h3f, {2'h0, lvl_a});
      chk("rx active data bit", 8'h3f, {2'h0, lvl_b});
      frm = '{tx_on: 1'b1, tx_parity_bit: 1'b1, rx_on: 1'b1, rx_parity_bit: 1'b1,
         default: 1'b0};
      step();
      step();
      chk("tx active parity high rate", 8'h00, {2'h0, lvl_a});
      chk("rx active parity high rate", 8'h00, {2'h0, lvl_b});
      frm = '{tx_on: 1'b1, tx_start_bit: 1'b0, tx_parity_bit: 1'b1, rx_on: 1'b1,
         rx_start_bit: 1'b0, rx_parity_bit: 1'b1, rate_106: 1'b1};
      step();
      step();
      chk("tx active parity", 8'h3f, {2'h0, lvl_a});
      chk("rx active parity", 8'h3f, {2'h0, lvl_b});
      grp = TOS_GRP_RX;
      line = 3'h6;
      rxp = 5'b10000;
      sel_a = TOS_SRC_LINE;
      step();
      step();
      chk("aux line d6", 8'h3f, {2'h0, lvl_a});
      line = 3'h5;
      step();
      step();
      chk("aux line d5", 8'h00, {2'h0, lvl_a});
   endtask

   task automatic t_prbs();
      int n;
      frm = '{tx_on: 1'b1, default: 1'b0};
      step();
      prbs = TOS_PRBS_9;
      step();
      chk("prbs idle", 8'h00, {7'h00, prbs_active});
      tx_cmd = 1'b1;
      step();
      tx_cmd = 1'b0;
      chk("prbs active", 8'h01, {7'h00, prbs_active});
      // one full period of a maximal 9-bit sequence holds 255 zeros
      n = 0;
      for (int i = 0; i < 511; i++)
      begin
         step();
         if (prbs_bit === 1'b0)
            n++;
      end
      chk("prbs9 zeros", 8'hff, 8'(n));
      // all-ones seed: fifteen ones, then the first feedback zero
      prbs = TOS_PRBS_15;
      tx_cmd = 1'b1;
      step();
      tx_cmd = 1'b0;
      n = 0;
      for (int i = 0; i < 16; i++)
      begin
         step();
         if (prbs_bit === 1'b1)
            n++;
      end
      chk("prbs15 ones", 8'h0f, 8'(n));
   endtask

   initial
   begin
      #(3000 * 100);
      num_errors++;
      end_sim();
   end

   initial
   begin
      repeat (8) @(posedge ref_clk);
      #10;
      rst = 1'b0;
      step();
      t_self_test();
      t_test_bus();
      t_aux();
      t_prbs();
      end_sim();
   end
endmodule
